// file: core/fws_pkg.sv
// Package: constants and carriers for the flash write-status poller
// Notes on behaviour
// - Host polls the program address, or an address inside an erasing sector.
// - After the top bit turns true, read once more before trusting data.
// - Host reads twice in a row; no toggle change means finished.
// - Toggling with failure bit high: recheck, then reset if still toggling.
// - Host that leaves the polling loop restarts from the double read.
// - After the failure bit rises and toggling persists on the recheck, host issues the reset command.
// - Host checks erase window bit around each added sector erase.
package fws_pkg;

  // ----------------------------------------------------------------
  // Register map of the host's own command port
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;  // W: start, mode, window check
  localparam logic [3:0] ADDR_TARGET = 4'h1;  // W: poll address
  localparam logic [3:0] ADDR_EXPECT = 4'h2;  // R/W: expected data
  localparam logic [3:0] ADDR_STATUS = 4'h3;  // R: poller status
  localparam logic [3:0] ADDR_LAST   = 4'h4;  // R: last word read
  localparam logic [3:0] ADDR_WINDOW = 4'h5;  // R: window check
  localparam int CTRL_START = 0;
  localparam int CTRL_ERASE = 1;
  localparam int CTRL_RESET = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RB   = 3;

  // Data bus bit positions of the status bits
  localparam int BIT_POLL  = 7;
  localparam int BIT_TOG1  = 6;
  localparam int BIT_FAIL  = 5;
  localparam int BIT_WIN   = 3;
  localparam int BIT_TOG2  = 2;

  // Flash reset command written to any address
  localparam logic [7:0]  CMD_RESET   = 8'hf0;
  localparam logic [19:0] RESET_ADDR  = 20'h00000;

  // ----------------------------------------------------------------
  // Bus cycle timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 10;
  localparam int READ_NS      = 120;  // Longest access of slowest grade
  localparam int READ_CYC     = (READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_NS     = 50;
  localparam int WRITE_CYC    = (WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] RD_CNT = 4'(READ_CYC);
  localparam logic [3:0] WR_CNT = 4'(WRITE_CYC);

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  data_out;
    logic        data_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } fws_flash_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fws_cmd_t;

endpackage : fws_pkg

// file: core/fws_sync.sv
// Two-stage synchroniser for the flash data bus and ready/busy pin
`timescale 1ns/1ns
module fws_sync (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic [8:0] async_in,
  output logic      [8:0] sync_out
);
  logic [8:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      stage1   <= 9'h1ff;
      sync_out <= 9'h1ff;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : fws_sync

// file: core/fws_poller.sv
// Host-side poller that runs the toggle and data polling algorithms
`timescale 1ns/1ns
module fws_poller (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire fws_pkg::fws_cmd_t cmd_in,
  output logic            [7:0]  rdata_out,
  input  wire logic       [7:0]  flash_data_in,
  input  wire logic              ready_busy_in,
  output fws_pkg::fws_flash_t    flash_out
);
  import fws_pkg::*;

  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_READ  = 7'b0000010,
    S_EVAL  = 7'b0000100,
    S_WRITE = 7'b0001000,
    S_DONE  = 7'b0010000,
    S_FAIL  = 7'b0100000,
    S_WCHK  = 7'b1000000
  } fws_state_t;

  typedef struct packed {
    fws_state_t  state;
    fws_flash_t  bus;
    logic [3:0]  cnt;
    logic [1:0]  nreads;    // 1 once the first read since the (re)start is stored
    logic [7:0]  prev;
    logic [7:0]  last;
    logic        erase;
    logic        fail_seen;
    logic        busy;
    logic        done;
    logic        failed;
    logic        win_req;
    logic        win_bit;
    logic [19:0] target;
    logic [7:0]  expect_d;
    logic [7:0]  rdata;
  } fws_regs_t;

  fws_regs_t r;
  fws_regs_t next_r;
  logic [8:0] pins_sync;
  logic [7:0] dq;
  logic       rb_pin;

  // Pins cross into the clock domain before any logic looks at them
  fws_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   ({ready_busy_in, flash_data_in}),
    .sync_out   (pins_sync)
  );
  assign dq     = pins_sync[7:0];
  assign rb_pin = pins_sync[8];

  // Status word seen by software
  function automatic logic [7:0] status_word(input fws_regs_t s,
                                              input logic rb);
    status_word = 8'h00;
    status_word[ST_BUSY] = s.busy;
    status_word[ST_DONE] = s.done;
    status_word[ST_FAIL] = s.failed;
    status_word[ST_RB]   = rb;
  endfunction : status_word

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    unique case (r.state)
      S_IDLE: begin
        if (r.busy || r.win_req) begin
          // Read cycle: ce and oe low, bus released
          next_r.bus.addr    = r.target;
          next_r.bus.ce_n    = 1'b0;
          next_r.bus.oe_n    = 1'b0;
          next_r.bus.data_oe = 1'b0;
          next_r.cnt         = RD_CNT;
          next_r.state       = S_READ;
        end
      end
      S_READ: begin
        if (r.cnt != 4'h0) begin
          next_r.cnt = r.cnt - 4'h1;
        end else begin
          next_r.bus.ce_n = 1'b1;
          next_r.bus.oe_n = 1'b1;
          next_r.prev     = r.last;
          next_r.last     = dq;
          next_r.state    = r.win_req ? S_WCHK : S_EVAL;
        end
      end
      S_WCHK: begin
        // Erase window check: 1 means no more sectors accepted
        next_r.win_bit = r.last[BIT_WIN];
        next_r.win_req = 1'b0;
        next_r.state   = S_IDLE;
      end
      S_EVAL: begin
        if (r.nreads == 2'd0) begin
          // First of the double read, only stored
          next_r.nreads = 2'd1;
          next_r.state  = S_IDLE;
        end else if (((r.prev ^ r.last) & 8'h44) == 8'h00) begin
          // No toggle: finished; this read was already the extra one
          // Quiet after a failure-flag recheck still counts as success
          next_r.busy   = 1'b0;
          next_r.done   = 1'b1;
          next_r.failed = 1'b0;
          next_r.state  = S_DONE;
          // Program: top bit must match expected data
          if (!r.erase && (r.last[BIT_POLL] != r.expect_d[BIT_POLL])) begin
            next_r.done   = 1'b0;
            next_r.failed = 1'b1;
          end
          // Erase done: polled bit is 1
          if (r.erase && !r.last[BIT_POLL]) begin
            next_r.done   = 1'b0;
            next_r.failed = 1'b1;
          end
        end else if (r.last[BIT_FAIL] && r.fail_seen) begin
          // Rechecked and still toggling with failure: reset
          next_r.bus.addr     = RESET_ADDR;
          next_r.bus.data_out = CMD_RESET;
          next_r.bus.data_oe  = 1'b1;
          next_r.bus.ce_n     = 1'b0;
          next_r.bus.we_n     = 1'b0;
          next_r.cnt          = WR_CNT;
          next_r.state        = S_WRITE;
        end else begin
          // Still toggling; remember a failure flag for one recheck
          next_r.fail_seen = r.last[BIT_FAIL];
          next_r.state     = S_IDLE;
        end
      end
      S_WRITE: begin
        if (r.cnt != 4'h0) begin
          next_r.cnt = r.cnt - 4'h1;
        end else begin
          // The part latches on the strobe's rising edge, so select and
          // data stay one cycle longer
          next_r.bus.we_n    = 1'b1;
          next_r.busy        = 1'b0;
          next_r.failed      = 1'b1;
          next_r.state       = S_FAIL;
        end
      end
      S_DONE: begin
        next_r.state = S_IDLE;
      end
      S_FAIL: begin
        // Release select and data once the strobe has risen
        next_r.bus.ce_n    = 1'b1;
        next_r.bus.data_oe = 1'b0;
        next_r.state       = S_IDLE;
      end
      default: begin
        next_r.state = S_IDLE;
      end
    endcase

    // Register port: writes and a read answered one cycle later
    next_r.rdata = 8'h00;
    if (cmd_in.rd) begin
      unique case (cmd_in.addr)
        ADDR_STATUS: next_r.rdata = status_word(r, rb_pin);
        ADDR_LAST:   next_r.rdata = r.last;
        ADDR_WINDOW: next_r.rdata = {6'h00, r.win_req, r.win_bit};
        ADDR_EXPECT: next_r.rdata = r.expect_d;
        default:     next_r.rdata = 8'h00;
      endcase
    end
    if (cmd_in.wr) begin
      unique case (cmd_in.addr)
        ADDR_TARGET: next_r.target = {12'h000, cmd_in.wdata};
        ADDR_EXPECT: next_r.expect_d = cmd_in.wdata;
        ADDR_CTRL: begin
          if (cmd_in.wdata[CTRL_START] && r.state == S_IDLE) begin
            // A new poll always restarts at the double read
            next_r.busy      = 1'b1;
            next_r.done      = 1'b0;
            next_r.failed    = 1'b0;
            next_r.nreads    = 2'd0;
            next_r.fail_seen = 1'b0;
            next_r.erase     = cmd_in.wdata[CTRL_ERASE];
          end
          if (cmd_in.wdata[CTRL_RESET] && r.state == S_IDLE) begin
            next_r.win_req = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      r       <= '0;
      r.state <= S_IDLE;
      r.bus   <= '{addr: 20'h00000, data_out: 8'h00, data_oe: 1'b0,
                   ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else begin
      r <= next_r;
    end
  end

  assign flash_out = r.bus;
  assign rdata_out = r.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_one_strobe;
    @(posedge ref_clk_in) disable iff (rst_in)
      !(flash_out.oe_n == 1'b0 && flash_out.we_n == 1'b0);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("oe and we low together");

  property p_drive_only_write;
    @(posedge ref_clk_in) disable iff (rst_in)
      flash_out.data_oe |-> !flash_out.we_n || $past(!flash_out.we_n);
  endproperty
  a_drive_only_write: assert property (p_drive_only_write)
    else $error("bus driven outside a write");

  property p_reset_after_fail;
    @(posedge ref_clk_in) disable iff (rst_in)
      (r.state == S_WRITE) |-> flash_out.data_out == CMD_RESET;
  endproperty
  a_reset_after_fail: assert property (p_reset_after_fail)
    else $error("wrong reset command");

  property p_double_read;
    @(posedge ref_clk_in) disable iff (rst_in)
      (r.state == S_EVAL && r.nreads == 2'd0) |=> r.busy;
  endproperty
  a_double_read: assert property (p_double_read)
    else $error("finished after a single read");

  // Reset command: strobe low six cycles, rises with data still held
  sequence s_cmd_low;
    !flash_out.we_n [*6];
  endsequence
  sequence s_cmd_hold;
    flash_out.we_n && !flash_out.ce_n && flash_out.data_oe;
  endsequence
  property p_cmd_pulse;
    @(posedge ref_clk_in) disable iff (rst_in)
      $fell(flash_out.we_n) |-> s_cmd_low ##1 s_cmd_hold;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("reset command strobe malformed");

  property p_read_target;
    @(posedge ref_clk_in) disable iff (rst_in)
      !flash_out.oe_n |-> flash_out.addr == r.target;
  endproperty
  a_read_target: assert property (p_read_target)
    else $error("status read away from the poll address");

  property p_done_quiet;
    @(posedge ref_clk_in) disable iff (rst_in)
      $rose(r.done) |-> r.prev[BIT_TOG1] == r.last[BIT_TOG1] &&
                        r.prev[BIT_TOG2] == r.last[BIT_TOG2];
  endproperty
  a_done_quiet: assert property (p_done_quiet)
    else $error("done while a toggle bit still moved");
endmodule : fws_poller

// file: dv/fws_flash_model.sv
// Behavioural flash device answering the poller's status reads
`timescale 1ns/1ns
module fws_flash_model (
  input  wire fws_pkg::fws_flash_t flash_in,
  input  wire logic                go_in,
  input  wire logic [1:0]          mode_in,
  input  wire logic [7:0]          data_in,
  input  wire logic [3:0]          reads_in,
  output logic      [7:0]          data_out,
  output logic                     ready_busy_out,
  output logic                     reset_seen_out
);
  import fws_pkg::*;
  logic       busy;
  logic       tog1;
  logic       tog2;
  logic [3:0] left;
  logic [7:0] word;
  logic [7:0] arr;
  logic       stuck;

  initial begin
    busy = 1'b0;
    tog1 = 1'b0;
    tog2 = 1'b0;
    left = 4'h0;
    word = 8'h00;
    arr = 8'hff;
    stuck = 1'b0;
    reset_seen_out = 1'b0;
  end

  // Start: status is live from the final command strobe
  always @(posedge go_in) begin
    busy = 1'b1;
    left = reads_in;
    // Stuck past the pulse limit, or a 1 over a 0: never ends by itself
    stuck = mode_in == 2'd2 ||
            (mode_in == 2'd0 && (data_in & ~arr) != 8'h00);
    reset_seen_out = 1'b0;
  end

  // Reset command aborts the operation and returns to array reads
  always @(posedge flash_in.we_n) begin
    if (!flash_in.ce_n && flash_in.data_oe &&
        flash_in.data_out == CMD_RESET) begin
      busy = 1'b0;
      reset_seen_out = 1'b1;
    end
  end

  // Each busy read cycle advances the toggles once and, unless stuck, spends one count
  always @(negedge flash_in.oe_n) begin
    if (!flash_in.ce_n && busy) begin
      // Erase: window bit low on the first status read only
      if (mode_in == 2'd1)
        word = {1'b0, tog1, 2'b00, left != reads_in, tog2, 2'b00};
      else
        word = {~data_in[7], tog1, stuck, data_in[4:0]};
      tog1 = ~tog1;
      tog2 = ~tog2;
      if (!stuck)
        left = left - 4'h1;
      // Mode 3 is a protected target: busy a while, array untouched
      if (left == 4'h0) begin
        busy = 1'b0;
        if (mode_in == 2'd0)
          arr = data_in;
        if (mode_in == 2'd1)
          arr = 8'hff;
      end
    end else if (!flash_in.ce_n)
      word = arr;
  end

  // Released bus shows the inverse so a stale value never looks right
  assign data_out = (!flash_in.ce_n && !flash_in.oe_n) ? word : ~word;
  // Open drain with pull-up: low only while the operation runs
  assign ready_busy_out = ~busy;
endmodule : fws_flash_model

// file: dv/test_flash_write_status_report.sv
// Self-checking bench for the flash write-status poller
`timescale 1ns/1ns
module test_flash_write_status_report;
  import fws_pkg::*;
  logic       ref_clk_in;
  logic       rst_in;
  fws_cmd_t   cmd;
  logic [7:0] rdata;
  logic [7:0] fdata;
  logic       rb;
  fws_flash_t fbus;
  logic       go;
  logic [1:0] mode;
  logic [7:0] wdat;
  logic [3:0] nreads;
  logic       rst_seen;
  logic       rd_seen;
  logic [8:0] notes[$];
  logic [8:0] note;
  logic [7:0] v;
  logic [7:0] img;
  int         err_count;
  int         tests_run;

  fws_poller fws_poller_i (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .cmd_in        (cmd),
    .rdata_out     (rdata),
    .flash_data_in (fdata),
    .ready_busy_in (rb),
    .flash_out     (fbus)
  );

  fws_flash_model fws_flash_model_i (
    .flash_in       (fbus),
    .go_in          (go),
    .mode_in        (mode),
    .data_in        (wdat),
    .reads_in       (nreads),
    .data_out       (fdata),
    .ready_busy_out (rb),
    .reset_seen_out (rst_seen)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // ----------------------------------------------------------------
  // Compare, report and register port tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // One strobe cycle then one idle cycle, so no edge sees two drives
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cmd <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    cmd <= '0;
    @(posedge ref_clk_in);
  endtask : wr

  // Bit 8 of the note says whether the answer is compared
  task automatic rd(input logic [3:0] a, input logic [8:0] n,
                    output logic [7:0] q);
    notes.push_back(n);
    cmd <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    cmd <= '0;
    @(posedge ref_clk_in);
    q = rdata;
  endtask : rd

  // Watcher: the answer stands only in the cycle after the strobe
  always @(posedge ref_clk_in) begin
    if (rd_seen) begin
      note = notes.pop_front();
      if (note[8]) check(rdata, note[7:0]);
    end
    rd_seen <= cmd.rd;
  end

  // ----------------------------------------------------------------
  // One operation: 0 program, 1 erase, 2 stuck, 3 protected target
  // ----------------------------------------------------------------
  task automatic run(input int i);
    logic [7:0] st;
    logic [7:0] exp;
    logic [7:0] e;
    logic       bad;
    int         n;
    // Two programs fall back to back, so a 1 over a 0 does occur
    mode <= 2'((i % 5) & 3);
    wdat <= 8'($urandom);
    nreads <= 4'(1 + $urandom % 8);
    @(posedge ref_clk_in);
    exp = (mode == 2'd1) ? 8'hff : wdat;
    // Stuck past the pulse limit, or a 1 over a 0 in the array
    bad = mode == 2'd2 || (mode == 2'd0 && (wdat & ~img) != 8'h00);
    wr(ADDR_EXPECT, exp);
    wr(ADDR_TARGET, 8'($urandom));
    go <= 1'b1;
    // Erase also asks for a window check on its first status read
    wr(ADDR_CTRL, (mode == 2'd1) ? 8'h07 : 8'h01);
    go <= 1'b0;
    st = 8'h01;
    for (n = 0; n < 400 && st[ST_BUSY] !== 1'b0; n++)
      rd(ADDR_STATUS, 9'h000, st);
    if (n == 400) begin
      err_count++;
      report_and_stop();
    end
    // A protected target leaves the array as it was
    if (mode == 2'd0 && !bad)
      img = wdat;
    if (mode == 2'd1)
      img = 8'hff;
    e = 8'(1 << ST_RB);
    if (!bad && img[7] == exp[7])
      e = e | 8'(1 << ST_DONE);
    else
      e = e | 8'(1 << ST_FAIL);
    rd(ADDR_STATUS, {1'b1, e}, st);
    if (!bad)
      rd(ADDR_LAST, {1'b1, img}, st);
    if (mode == 2'd1)
      rd(ADDR_WINDOW, 9'h100, st);
    check({7'h00, rst_seen}, {7'h00, bad});
    $display("test %0d mode %0d over", i, mode);
  endtask : run

  // Limit on the whole run; a hang counts as a mismatch
  initial begin
    #900000;
    err_count++;
    report_and_stop();
  end

  initial begin
    rst_in = 1'b1;
    cmd = '0;
    go = 1'b0;
    mode = 2'd0;
    wdat = 8'h00;
    nreads = 4'h1;
    img = 8'hff;
    rd_seen = 1'b0;
    err_count = 0;
    tests_run = 0;
    void'($urandom(32'hd108));
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rd(ADDR_STATUS, {1'b1, 8'(1 << ST_RB)}, v);
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, {1'b1, 8'(1 << ST_RB)}, v);
    rd(4'hf, 9'h100, v);
    $display("test idle over");
    for (int i = 0; i < 15; i++)
      run(i);
    repeat (2) @(posedge ref_clk_in);
    report_and_stop();
  end
endmodule : test_flash_write_status_report
